// ---- verilog/cdh_config_ctrl.sv ----
`timescale 1ns/1ps
`include "cdh_consts.svh"
// Overview of operation
// - The done-status line is pulled low from before configuration and through the whole data transfer.
// - Once all data arrived without error, the done-status line is released, before initialisation starts.
// - The done-status line is sensed, and initialisation then user mode follow only once it reads high.
// - In user mode an external low on the done-status line is ignored.
// - Configuration proceeds only while the active-low chain-enable input is low.
// - The chain-enable output is driven low once this device enters user mode, after initialisation.
// - With the option on the chain-enable output stays dedicated, otherwise it takes the user pin setting.
// - In active serial mode the flash-select output enables the serial memory while data is read.
// - In active parallel mode the same output is the active-low chip enable of the parallel flash.
// - A low restart request discards the configuration, resets, tri-states I/O, and its release restarts.
// - Errors pull the error-status line low, and an external low on it during load or init is an error.
module cdh_config_ctrl
  import cdh_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Pins sensed from outside
  input wire logic config_restart_request_n_i,
  input wire logic chain_enable_n_i,
  input wire logic config_complete_status_i,
  input wire logic error_status_i,
  // Straps and pin options
  input wire logic active_serial_mode_i,
  input wire logic active_parallel_mode_i,
  input wire logic ceo_dedicated_i,
  input wire logic ceo_user_level_i,
  // Configuration data path, same clock
  input wire logic load_done_i,
  input wire logic load_error_i,
  // Pins driven
  output cdh_pin_t config_complete_status_o,
  output cdh_pin_t error_status_o,
  output cdh_pin_t chain_enable_out_n_o,
  output logic flash_select_n_o,
  // Core status
  output logic io_tristate_o,
  output logic load_enable_o,
  output logic user_mode_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`CDH_PIN_W-1:0] pins_s;

  cdh_sync2 #(
    .W(`CDH_PIN_W),
    .RST_VAL(`CDH_PIN_RST_VAL)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({ceo_user_level_i, ceo_dedicated_i, active_parallel_mode_i, active_serial_mode_i,
          error_status_i, config_complete_status_i, chain_enable_n_i, config_restart_request_n_i}),
    .q_o(pins_s)
  );

  logic restart_n_s;
  logic chain_en_n_s;
  logic done_s;
  logic err_s;
  logic flash_mode_s;

  assign restart_n_s = pins_s[`CDH_BIT_RESTART_N];
  assign chain_en_n_s = pins_s[`CDH_BIT_CHAIN_EN_N];
  assign done_s = pins_s[`CDH_BIT_DONE];
  assign err_s = pins_s[`CDH_BIT_ERR];
  assign flash_mode_s = pins_s[`CDH_BIT_AS] | pins_s[`CDH_BIT_AP];

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  cdh_state_t state_reg;
  cdh_state_t state_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic fault;

  // Own error drive only exists in the error state, so a low here is external
  assign fault = load_error_i | ~err_s;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      CDH_ST_RESET: begin
        if (restart_n_s) begin
          state_next = CDH_ST_WAIT;
        end
      end
      CDH_ST_WAIT: begin
        if (!chain_en_n_s) begin
          state_next = CDH_ST_LOAD;
        end
      end
      CDH_ST_LOAD: begin
        if (chain_en_n_s) begin
          state_next = CDH_ST_WAIT;
        end else if (fault) begin
          state_next = CDH_ST_ERROR;
        end else if (load_done_i) begin
          state_next = CDH_ST_RELEASE;
        end
      end
      CDH_ST_RELEASE: begin
        if (fault) begin
          state_next = CDH_ST_ERROR;
        end else if (done_s) begin
          state_next = CDH_ST_INIT;
          cnt_next = `CDH_CNT_ZERO;
        end
      end
      CDH_ST_INIT: begin
        cnt_next = 8'(cnt_reg + `CDH_CNT_ONE);
        if (fault) begin
          state_next = CDH_ST_ERROR;
        end else if (cnt_reg == `CDH_INIT_LAST) begin
          state_next = CDH_ST_USER;
        end
      end
      CDH_ST_USER: begin
        state_next = CDH_ST_USER;
      end
      CDH_ST_ERROR: begin
        state_next = CDH_ST_ERROR;
      end
      default: begin
        state_next = CDH_ST_RESET;
      end
    endcase
    if (!restart_n_s) begin
      state_next = CDH_ST_RESET;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= CDH_ST_RESET;
      cnt_reg <= `CDH_CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------
  // Registered pin outputs
  // ----------------------------------------
  cdh_pin_t done_reg, done_next;
  cdh_pin_t err_reg, err_next;
  cdh_pin_t ceo_reg, ceo_next;
  logic flash_n_reg, flash_n_next;
  logic tri_reg, tri_next;
  logic load_en_reg, load_en_next;
  logic user_reg, user_next;

  always_comb begin
    done_next.o = 1'b0;
    done_next.oe = (state_next == CDH_ST_RESET) || (state_next == CDH_ST_WAIT) ||
                   (state_next == CDH_ST_LOAD) || (state_next == CDH_ST_ERROR);
    err_next.o = 1'b0;
    err_next.oe = (state_next == CDH_ST_ERROR);
    ceo_next.o = 1'b1;
    ceo_next.oe = 1'b0;
    if (state_next == CDH_ST_USER) begin
      ceo_next.oe = 1'b1;
      ceo_next.o = ceo_dedicated_reg_sel(pins_s[`CDH_BIT_CEO_DED], pins_s[`CDH_BIT_CEO_USER]);
    end
    flash_n_next = ~((state_next == CDH_ST_LOAD) && flash_mode_s);
    tri_next = (state_next != CDH_ST_USER);
    load_en_next = (state_next == CDH_ST_LOAD);
    user_next = (state_next == CDH_ST_USER);
  end

  function automatic logic ceo_dedicated_reg_sel(input logic ded, input logic lvl);
    ceo_dedicated_reg_sel = ded ? 1'b0 : lvl;
  endfunction

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_reg <= `CDH_DONE_RST;
      err_reg <= `CDH_ERR_RST;
      ceo_reg <= `CDH_CEO_RST;
      flash_n_reg <= 1'b1;
      tri_reg <= 1'b1;
      load_en_reg <= 1'b0;
      user_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
      err_reg <= err_next;
      ceo_reg <= ceo_next;
      flash_n_reg <= flash_n_next;
      tri_reg <= tri_next;
      load_en_reg <= load_en_next;
      user_reg <= user_next;
    end
  end

  assign config_complete_status_o = done_reg;
  assign error_status_o = err_reg;
  assign chain_enable_out_n_o = ceo_reg;
  assign flash_select_n_o = flash_n_reg;
  assign io_tristate_o = tri_reg;
  assign load_enable_o = load_en_reg;
  assign user_mode_o = user_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_loading;
    state_reg == CDH_ST_LOAD;
  endsequence

  sequence s_load_finished;
    s_loading ##1 (state_reg == CDH_ST_RELEASE);
  endsequence

  property p_done_low_in_load;
    s_loading |-> done_reg.oe && !done_reg.o;
  endproperty
  a_done_low_in_load: assert property (p_done_low_in_load) else $error("done line not pulled in load");

  property p_done_released;
    s_load_finished |-> !done_reg.oe;
  endproperty
  a_done_released: assert property (p_done_released) else $error("done line held after load");

  property p_init_waits_done;
    (state_reg == CDH_ST_RELEASE && !done_s && restart_n_s) |=> state_reg != CDH_ST_INIT;
  endproperty
  a_init_waits_done: assert property (p_init_waits_done) else $error("init before done seen high");

  property p_init_length;
    (state_reg == CDH_ST_INIT && cnt_reg == `CDH_CNT_ZERO) ##1 (state_reg == CDH_ST_INIT)[*8]
      |-> !user_mode_o;
  endproperty
  a_init_length: assert property (p_init_length) else $error("user mode entered too early");

  property p_user_holds;
    (state_reg == CDH_ST_USER && restart_n_s) |=> state_reg == CDH_ST_USER && user_mode_o;
  endproperty
  a_user_holds: assert property (p_user_holds) else $error("user mode left without restart");

  property p_chain_gate;
    (state_reg == CDH_ST_WAIT && chain_en_n_s) |=> state_reg != CDH_ST_LOAD;
  endproperty
  a_chain_gate: assert property (p_chain_gate) else $error("load began with chain disabled");

  property p_ceo_done;
    (user_mode_o && pins_s[`CDH_BIT_CEO_DED]) |-> chain_enable_out_n_o.oe && !chain_enable_out_n_o.o;
  endproperty
  a_ceo_done: assert property (p_ceo_done) else $error("chain output not low in user mode");

  property p_ceo_idle;
    !user_mode_o |-> !chain_enable_out_n_o.oe;
  endproperty
  a_ceo_idle: assert property (p_ceo_idle) else $error("chain output driven before done");

  property p_flash_sel;
    (s_loading and flash_mode_s) |-> !flash_select_n_o ##0 load_enable_o;
  endproperty
  a_flash_sel: assert property (p_flash_sel) else $error("flash not selected in load");

  property p_restart;
    !restart_n_s |=> state_reg == CDH_ST_RESET && io_tristate_o && !user_mode_o;
  endproperty
  a_restart: assert property (p_restart) else $error("restart request not honoured");

  property p_error_drive;
    (s_loading and (load_error_i && !chain_en_n_s && restart_n_s)) |=> error_status_o.oe;
  endproperty
  a_error_drive: assert property (p_error_drive) else $error("error line not pulled");

endmodule

// ---- verilog/cdh_consts.svh ----
`ifndef CDH_CONSTS_SVH
`define CDH_CONSTS_SVH

// Initialisation length in clock cycles
`define CDH_INIT_CYCLES 8'h40
`define CDH_INIT_LAST 8'h3f
`define CDH_CNT_ZERO 8'h00
`define CDH_CNT_ONE 8'h01

// Synchroniser bit positions
`define CDH_PIN_W 8
`define CDH_BIT_RESTART_N 0
`define CDH_BIT_CHAIN_EN_N 1
`define CDH_BIT_DONE 2
`define CDH_BIT_ERR 3
`define CDH_BIT_AS 4
`define CDH_BIT_AP 5
`define CDH_BIT_CEO_DED 6
`define CDH_BIT_CEO_USER 7

// Idle levels of pins before first sample
`define CDH_PIN_RST_VAL 8'h0f

// Pin output reset values {o, oe}
`define CDH_DONE_RST 2'h1
`define CDH_ERR_RST 2'h0
`define CDH_CEO_RST 2'h2

`endif

// ---- verilog/cdh_pkg.sv ----
package cdh_pkg;

  // Open-drain or driven pin: level and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } cdh_pin_t;

  typedef enum logic [2:0] {
    CDH_ST_RESET   = 3'b000,
    CDH_ST_WAIT    = 3'b001,
    CDH_ST_LOAD    = 3'b010,
    CDH_ST_RELEASE = 3'b011,
    CDH_ST_INIT    = 3'b100,
    CDH_ST_USER    = 3'b101,
    CDH_ST_ERROR   = 3'b110
  } cdh_state_t;

endpackage

// ---- verilog/cdh_sync2.sv ----
`timescale 1ns/1ps
module cdh_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;

endmodule

// ---- tb/cdh_partner.sv ----
`timescale 1ns/1ps
module cdh_partner
  import cdh_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Device pins
  input wire cdh_pin_t done_i,
  input wire cdh_pin_t err_i,
  input wire cdh_pin_t ceo_i,
  input wire logic load_en_i,
  // Controls
  input wire logic hold_done_i,
  input wire logic hold_err_i,
  input wire logic slow_i,
  // Wire levels and host
  output logic done_w_o,
  output logic err_w_o,
  output logic ceo_w_o,
  output logic load_done_o
);
  logic [3:0] wait_reg;
  // Pull-ups on the open-drain wires
  assign done_w_o = !(done_i.oe || hold_done_i);
  assign err_w_o = !(err_i.oe || hold_err_i);
  assign ceo_w_o = ceo_i.oe ? ceo_i.o : 1'b1;
  // Host ends the data transfer after a short or long delay
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_reg <= 4'h0;
      load_done_o <= 1'b0;
    end else begin
      load_done_o <= 1'b0;
      if (!load_en_i || load_done_o) begin
        wait_reg <= 4'h0;
      end else if (wait_reg == (slow_i ? 4'h9 : 4'h1)) begin
        load_done_o <= 1'b1;
        wait_reg <= 4'h0;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

// ---- tb/config_done_chain_handshake_bench.sv ----
`timescale 1ns/1ps
module config_done_chain_handshake_bench;
  import cdh_pkg::*;
  logic clk_i = 0, reset_i = 1, rst_n = 1, as_m = 1, ap_m = 0, ded = 1, lvl = 0;
  logic chain_n = 0;
  logic hold_done = 0, hold_err = 0, slow = 1, load_err = 0, done_w, err_w, ceo_w, ld;
  logic flash_n, tri_s, load_en, user;
  cdh_pin_t done_p, err_p, ceo_p;
  int n_errors = 0, tests_run = 0;
  cdh_config_ctrl cdh_config_ctrl_inst (.clk_i(clk_i), .reset_i(reset_i),
    .config_restart_request_n_i(rst_n), .chain_enable_n_i(chain_n),
    .config_complete_status_i(done_w), .error_status_i(err_w),
    .active_serial_mode_i(as_m), .active_parallel_mode_i(ap_m),
    .ceo_dedicated_i(ded), .ceo_user_level_i(lvl), .load_done_i(ld),
    .load_error_i(load_err), .config_complete_status_o(done_p), .error_status_o(err_p),
    .chain_enable_out_n_o(ceo_p), .flash_select_n_o(flash_n), .io_tristate_o(tri_s),
    .load_enable_o(load_en), .user_mode_o(user));
  cdh_partner cdh_partner_inst (.clk_i(clk_i), .reset_i(reset_i), .done_i(done_p),
    .err_i(err_p), .ceo_i(ceo_p), .load_en_i(load_en), .hold_done_i(hold_done),
    .hold_err_i(hold_err), .slow_i(slow), .done_w_o(done_w), .err_w_o(err_w),
    .ceo_w_o(ceo_w), .load_done_o(ld));
  initial forever #2 clk_i = ~clk_i;
  // ------
  // Helpers
  // ------
  task chk(input logic [1:0] seen, input logic [1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wait_load;
    for (int i = 0; i < 30 && load_en !== 1'b1; i++) cyc(1);
  endtask
  task wait_user;
    for (int i = 0; i < 200 && user !== 1'b1; i++) cyc(1);
  endtask
  task restart;
    @(posedge clk_i) rst_n <= 1'b0;
    cyc(4);
    chk(user, 0); chk(tri_s, 1); chk(done_p.oe, 1); chk(ceo_p.oe, 0);
    @(posedge clk_i) rst_n <= 1'b1;
  endtask
  task stop_test;
    $display("Errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  task t_serial;
    cyc(1);
    chk(done_p, 2'b01);
    wait_load();
    chk(load_en, 1); chk(flash_n, 0); chk(done_p, 2'b01);
    for (int i = 0; i < 30 && load_en === 1'b1; i++) cyc(1);
    chk(done_p.oe, 0); chk(flash_n, 1);
    chk(ceo_p.oe, 0);
    cyc(60);
    chk(user, 0); chk(ceo_w, 1);
    wait_user();
    chk(user, 1); chk(tri_s, 0);
    chk(ceo_p, 2'b01); chk(ceo_w, 0);
    @(posedge clk_i) hold_done <= 1'b1;
    cyc(8);
    chk(user, 1); chk(tri_s, 0);
    @(posedge clk_i) hold_done <= 1'b0;
  endtask
  task t_done_held;
    @(posedge clk_i) hold_done <= 1'b1;
    restart();
    cyc(120);
    chk(user, 0); chk(load_en, 0);
    @(posedge clk_i) hold_done <= 1'b0;
    wait_user();
    chk(user, 1);
  endtask
  task t_chain_off;
    @(posedge clk_i) chain_n <= 1'b1;
    restart();
    cyc(20);
    chk(load_en, 0); chk(flash_n, 1);
    @(posedge clk_i) chain_n <= 1'b0;
    wait_load();
    chk(load_en, 1);
  endtask
  task t_error;
    @(posedge clk_i) hold_err <= 1'b1;
    cyc(4);
    chk(err_p.oe, 1); chk(load_en, 0);
    @(posedge clk_i) hold_err <= 1'b0;
    cyc(6);
    chk(err_p, 2'b01); chk(user, 0);
    restart();
    cyc(4);
    chk(err_p.oe, 0); chk(load_en, 1);
    @(posedge clk_i) load_err <= 1'b1;
    @(posedge clk_i) load_err <= 1'b0;
    cyc(1);
    chk(err_p, 2'b01); chk(load_en, 0);
  endtask
  task t_parallel;
    @(posedge clk_i) as_m <= 1'b0;
    ap_m <= 1'b1;
    ded <= 1'b0;
    lvl <= 1'b1;
    slow <= 1'b0;
    restart();
    wait_load();
    chk(flash_n, 0);
    wait_user();
    chk(ceo_p, 2'b11); chk(ceo_w, 1);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    t_serial();
    t_done_held();
    t_chain_off();
    t_error();
    t_parallel();
    stop_test();
  end
  initial begin
    #40000;
    n_errors++;
    stop_test();
  end
endmodule
